// *** verilog/divp_params.svh ***
// divp_params.svh: constants of the interrupt vector and priority block
// assumes inclusion by the block's top module divp_ctrl only
`ifndef DIVP_PARAMS_SVH
`define DIVP_PARAMS_SVH

`define DIVP_NSRC        14
`define DIVP_VEC_RESET   7'h00
`define DIVP_VEC_NMI     7'h04
`define DIVP_VEC_TRAP17  7'h08
`define DIVP_VEC_TRAP30  7'h3C
`define DIVP_VEC_HW0     7'h40
`define DIVP_RSV_LO      7'h78
`define DIVP_RSV_HI      7'h7F
`define DIVP_VEC_STEP    7'h04
`define DIVP_PRIO_RESET  5'h01
`define DIVP_PRIO_NMI    5'h02
`define DIVP_PRIO_HW0    5'h03
`define DIVP_PRIO_NONE   5'h00
`define DIVP_MASK_RST    14'h0000

`endif

// *** verilog/divp_pkg.sv ***
// divp_pkg.sv: types of the interrupt vector and priority block
// assumes the params header sits beside it
`default_nettype none
package divp_pkg;
	typedef enum logic [1:0] {
		DIVP_IDLE,
		DIVP_WAIT_ACK
	} divp_state_t;

	typedef struct packed {
		divp_state_t state;
		logic [13:0] pending_flag_register;
		logic [13:0] mask_register;
		logic [13:0] req_s1;
		logic [13:0] req_s2;
		logic [13:0] req_d;
		logic [1:0]  nmi_s;
		logic        nmi_d;
		logic        nmi_pend;
		logic        take;
		logic [6:0]  vector;
		logic [4:0]  prio;
		logic        reserved_hit;
	} divp_state_s_t;
endpackage
`default_nettype wire

// *** verilog/divp_ctrl.sv ***
// divp_ctrl.sv: vector selection and fixed-priority arbitration of interrupt sources
// assumes request pins are asynchronous; core acknowledges each taken vector
`include "divp_params.svh"
`default_nettype none
module divp_ctrl
	import divp_pkg::*;
(
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	// hardware sources, bit order: ext0 ext1 ext2 timer p0rx p0tx p2rx p2tx ext3 host p1rx p1tx dma4 dma5
	input  wire logic        ext_request_zero_i,
	input  wire logic        ext_request_one_i,
	input  wire logic        ext_request_two_i,
	input  wire logic        timer_request_i,
	input  wire logic        port0_rx_request_i,
	input  wire logic        port0_tx_request_i,
	input  wire logic        port2_rx_request_i,
	input  wire logic        port2_tx_request_i,
	input  wire logic        ext_request_three_i,
	input  wire logic        host_port_request_i,
	input  wire logic        port1_rx_request_i,
	input  wire logic        port1_tx_request_i,
	input  wire logic        dma_ch4_request_i,
	input  wire logic        dma_ch5_request_i,
	input  wire logic        nmi_request_i,
	// core side
	input  wire logic        soft_reset_trap_i,
	input  wire logic        soft_trap_i,
	input  wire logic [4:0]  soft_trap_num_i,
	input  wire logic        mask_we_i,
	input  wire logic [13:0] mask_wdata_i,
	input  wire logic        flag_clr_i,
	input  wire logic [13:0] flag_clr_bits_i,
	input  wire logic        ack_i,
	output logic             take_o,
	output logic [6:0]       vector_o,
	output logic [4:0]       prio_o,
	output logic             reserved_hit_o,
	output logic [13:0]      pending_o,
	output logic [13:0]      mask_o
);

	divp_state_s_t st_reg;
	divp_state_s_t st_next;
	logic [13:0]   req_raw;
	logic [13:0]   eligible;
	logic [3:0]    win;
	logic          win_v;
	logic [13:0]   rise;

	assign req_raw = {dma_ch5_request_i, dma_ch4_request_i, port1_tx_request_i, port1_rx_request_i,
		host_port_request_i, ext_request_three_i, port2_tx_request_i, port2_rx_request_i,
		port0_tx_request_i, port0_rx_request_i, timer_request_i, ext_request_two_i,
		ext_request_one_i, ext_request_zero_i};

	// ************************************************************
	// vector arithmetic
	// ************************************************************
	// slot index to location, four words apart
	function automatic logic [6:0] divp_hw_vec(input logic [3:0] idx);
		divp_hw_vec = 7'(`DIVP_VEC_HW0 + {1'b0, idx, 2'b00});
	endfunction

	// slot index to priority number
	function automatic logic [4:0] divp_hw_prio(input logic [3:0] idx);
		divp_hw_prio = 5'(`DIVP_PRIO_HW0 + {1'b0, idx});
	endfunction

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_next = st_reg;
		st_next.req_s1 = req_raw;
		st_next.req_s2 = st_reg.req_s1;
		st_next.req_d = st_reg.req_s2;
		st_next.nmi_s = {st_reg.nmi_s[0], nmi_request_i};
		st_next.nmi_d = st_reg.nmi_s[1];
		st_next.reserved_hit = 1'b0;
		eligible = '0;
		win = 4'h0;
		win_v = 1'b0;

		if (mask_we_i) begin
			st_next.mask_register = mask_wdata_i;
		end

		rise = st_reg.req_s2 & ~st_reg.req_d;
		if (flag_clr_i) begin
			st_next.pending_flag_register = st_reg.pending_flag_register & ~flag_clr_bits_i;
		end
		st_next.pending_flag_register = st_next.pending_flag_register | rise;
		if (st_reg.nmi_s[1] && !st_reg.nmi_d) begin
			st_next.nmi_pend = 1'b1;
		end

		eligible = st_reg.pending_flag_register & st_reg.mask_register;
		for (int i = `DIVP_NSRC - 1; i >= 0; i--) begin
			if (eligible[i]) begin
				win = 4'(i);
				win_v = 1'b1;
			end
		end

		case (st_reg.state)
			DIVP_IDLE: begin
				if (soft_reset_trap_i) begin
					st_next.take = 1'b1;
					st_next.vector = `DIVP_VEC_RESET;
					st_next.prio = `DIVP_PRIO_RESET;
					st_next.state = DIVP_WAIT_ACK;
				end else if (st_reg.nmi_pend) begin
					st_next.take = 1'b1;
					st_next.vector = `DIVP_VEC_NMI;
					st_next.prio = `DIVP_PRIO_NMI;
					st_next.nmi_pend = 1'b0;
					st_next.state = DIVP_WAIT_ACK;
				end else if (win_v) begin
					st_next.take = 1'b1;
					st_next.vector = divp_hw_vec(win);
					st_next.prio = divp_hw_prio(win);
					// a fresh edge in the same cycle stays pending
					st_next.pending_flag_register[win] = rise[win];
					st_next.state = DIVP_WAIT_ACK;
				end else if (soft_trap_i) begin
					st_next.take = 1'b1;
					st_next.prio = `DIVP_PRIO_NONE;
					if (soft_trap_num_i <= 5'd13) begin
						st_next.vector = divp_hw_vec(soft_trap_num_i[3:0]);
					end else if (soft_trap_num_i == 5'd16) begin
						st_next.vector = `DIVP_VEC_NMI;
					end else if (soft_trap_num_i >= 5'd17 && soft_trap_num_i <= 5'd30) begin
						st_next.vector = 7'(`DIVP_VEC_TRAP17 + {soft_trap_num_i - 5'd17, 2'b00});
					end else begin
						st_next.take = 1'b0;
						st_next.vector = `DIVP_RSV_LO;
						st_next.reserved_hit = 1'b1;
					end
					if (st_next.take) begin
						st_next.state = DIVP_WAIT_ACK;
					end
				end
			end
			DIVP_WAIT_ACK: begin
				// vector held until the core takes it
				if (ack_i) begin
					st_next.take = 1'b0;
					st_next.state = DIVP_IDLE;
				end
			end
			default: begin
				st_next.state = DIVP_IDLE;
				st_next.take = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg <= '0;
			st_reg.state <= DIVP_IDLE;
			st_reg.mask_register <= `DIVP_MASK_RST;
			st_reg.vector <= `DIVP_VEC_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign take_o = st_reg.take;
	assign vector_o = st_reg.vector;
	assign prio_o = st_reg.prio;
	assign reserved_hit_o = st_reg.reserved_hit;
	assign pending_o = st_reg.pending_flag_register;
	assign mask_o = st_reg.mask_register;

endmodule // divp_ctrl
`default_nettype wire

// *** verif/divp_core_model.sv ***
// divp_core_model.sv: core side, acks each taken vector
// assumes take_i holds until the ack is seen
`default_nettype none
module divp_core_model (
	input  wire logic       mclk_i,
	input  wire logic       take_i,
	input  wire logic [1:0] dly_i,
	output var  logic       ack_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt_reg;
	always_ff @(posedge mclk_i) begin
		cnt_reg <= take_i ? cnt_reg + 2'h1 : 2'h0;
		ack_o   <= take_i && !ack_o && cnt_reg == dly_i;
	end
endmodule // divp_core_model
`default_nettype wire

// *** verif/divp_ctrl_asserts.sv ***
// divp_ctrl_asserts.sv: port checks of divp_ctrl
// assumes one clock, bound below
`default_nettype none
module divp_ctrl_asserts (
	input wire logic        mclk_i,
	input wire logic        resetn_i,
	input wire logic        soft_reset_trap_i,
	input wire logic        ack_i,
	input wire logic        take_o,
	input wire logic [6:0]  vector_o,
	input wire logic [4:0]  prio_o,
	input wire logic [13:0] pending_o,
	input wire logic [13:0] mask_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_hw; $rose(take_o) && prio_o > 5'h02; endsequence
	property p_rst; soft_reset_trap_i && !take_o |=> take_o && vector_o == 7'h00 && prio_o == 5'h01; endproperty
	property p_nmi; take_o && prio_o == 5'h02 |-> vector_o == 7'h04; endproperty
	property p_map; take_o && prio_o > 5'h02 |-> vector_o == 7'h40 + {prio_o - 5'h03, 2'b00}; endproperty
	property p_rsv; take_o |-> vector_o < 7'h78; endproperty
	property p_hold; take_o && !ack_i |=> take_o && $stable(vector_o) && $stable(prio_o); endproperty
	property p_drop; take_o && ack_i |=> !take_o; endproperty
	property p_mask; s_hw |-> $past(mask_o) >> (prio_o - 5'h03) & 14'h0001; endproperty
	property p_win; s_hw |-> ($past(pending_o & mask_o) & ((14'h0001 << (prio_o - 5'h03)) - 14'h0001)) == 14'h0000;
	endproperty
	a_rst: assert property (p_rst) else $error("reset vector");
	a_nmi: assert property (p_nmi) else $error("nmi vector");
	a_map: assert property (p_map) else $error("slot vector");
	a_rsv: assert property (p_rsv) else $error("reserved vector");
	a_hold: assert property (p_hold) else $error("vector moved");
	a_drop: assert property (p_drop) else $error("take held");
	a_mask: assert property (p_mask) else $error("masked taken");
	a_win: assert property (p_win) else $error("order wrong");
endmodule // divp_ctrl_asserts
bind divp_ctrl divp_ctrl_asserts u_chk (.*);
`default_nettype wire

// *** verif/tb_top.sv ***
// tb_top.sv: directed and random checks of divp_ctrl
// assumes the core model acks each vector
`default_nettype none
`define CHK(a,b) begin cmp_count++; if ((a)!==(b)) begin fail_count++; $display("[FAIL] %0t %h %h",$time,a,b); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk_i = 0, resetn_i = 0, nmi_request_i = 0, soft_reset_trap_i = 0, soft_trap_i = 0;
	logic        ack_i, take_o, reserved_hit_o;
	logic [1:0]  dly = 0;
	logic [4:0]  soft_trap_num_i = 0, prio_o;
	logic [6:0]  vector_o;
	logic [13:0] src = 0, mask_wdata_i = 14'h0000, pending_o, mask_o;
	logic        mask_we_i = 0, flag_clr_i = 0;
	logic [13:0] flag_clr_bits_i = 0;
	int          fail_count = 0, cmp_count = 0, i, r, n;
	divp_core_model CORE (.mclk_i(mclk_i), .take_i(take_o), .dly_i(dly), .ack_o(ack_i));
	divp_ctrl DUT (
		.ext_request_zero_i(src[0]), .ext_request_one_i(src[1]), .ext_request_two_i(src[2]),
		.timer_request_i(src[3]), .port0_rx_request_i(src[4]), .port0_tx_request_i(src[5]),
		.port2_rx_request_i(src[6]), .port2_tx_request_i(src[7]), .ext_request_three_i(src[8]),
		.host_port_request_i(src[9]), .port1_rx_request_i(src[10]), .port1_tx_request_i(src[11]),
		.dma_ch4_request_i(src[12]), .dma_ch5_request_i(src[13]), .*);
	initial forever #5 mclk_i = ~mclk_i;
	function automatic logic [6:0] tv(int k);
		return k < 14 ? 7'(64 + 4 * k) : k == 16 ? 7'h04 : 7'(8 + 4 * (k - 17));
	endfunction
	task automatic summarize(input int to);
		fail_count += to;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// soft inputs dropped once taken, else they would be taken again
	task automatic svc(input logic [6:0] v, input logic [4:0] p);
		for (n = 0; take_o !== 1'b1 && n < 40; n++) @(negedge mclk_i);
		if (n == 40) summarize(1);
		`CHK(vector_o, v)
		`CHK(prio_o, p)
		@(posedge mclk_i);
		{src, soft_trap_i, soft_reset_trap_i, nmi_request_i} <= '0;
		for (n = 0; take_o !== 1'b0 && n < 40; n++) @(negedge mclk_i);
		if (n == 40) summarize(1);
	endtask
	initial begin
		void'($urandom(36));
		repeat (10) @(posedge mclk_i);
		resetn_i <= 1;
		@(negedge mclk_i);
		`CHK(mask_o, 14'h0000)
		@(posedge mclk_i);
		soft_reset_trap_i <= 1;
		svc(7'h00, 5'h01);
		@(posedge mclk_i);
		nmi_request_i <= 1;
		svc(7'h04, 5'h02);
		@(posedge mclk_i);
		src <= 14'h0003;
		repeat (8) @(posedge mclk_i);
		@(negedge mclk_i);
		`CHK(pending_o, 14'h0003)
		`CHK(take_o, 1'b0)
		@(posedge mclk_i);
		flag_clr_i <= 1;
		flag_clr_bits_i <= 14'h0002;
		@(posedge mclk_i);
		flag_clr_i <= 0;
		@(negedge mclk_i);
		`CHK(pending_o, 14'h0001)
		@(posedge mclk_i);
		mask_wdata_i <= 14'h3FFF;
		mask_we_i <= 1;
		@(posedge mclk_i);
		mask_we_i <= 0;
		svc(7'h40, 5'h03);
		repeat (20) begin
			@(posedge mclk_i);
			r = $urandom;
			dly <= 2'(r);
			src <= 14'(r);
			for (i = 0; i < 14; i++) if (r[i]) svc(tv(i), 5'(i + 3));
		end
		for (i = 0; i < 32; i++) begin
			@(posedge mclk_i);
			{soft_trap_i, soft_trap_num_i} <= 6'(32 + i);
			if (i inside {14, 15, 31}) begin
				@(posedge mclk_i);
				soft_trap_i <= 0;
				@(negedge mclk_i);
				`CHK(reserved_hit_o, 1'b1)
			end else svc(tv(i), 5'h00);
		end
		summarize(0);
	end
endmodule // tb_top
`default_nettype wire
